/* File: rtl/timer_defines.svh */
// timer block: register offsets, field positions, reset values, prescaler taps
// assumes inclusion by the timer modules; the package does not include it
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADDR_CTRL_A 8'h15
`define ADDR_CTRL_B 8'h33
`define ADDR_COUNT_LOW 8'h12
`define ADDR_COUNT_HIGH 8'h14
`define ADDR_COMPARE_A 8'h13
`define ADDR_COMPARE_B 8'h11
`define ADDR_FLAGS 8'h18
`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define CTRL_A_WMASK 8'hF9
`define CTRL_B_WMASK 8'h1F
`define A_WIDTH 7
`define A_CAPEN 6
`define A_FILT 5
`define A_EDGE 4
`define A_ACIC 3
`define A_CTC 0
`define B_SYNC 4
`define B_PSR 3
`define B_CS_MSB 2
`define FLAG_CAP 0
`define FLAG_OVF 1
`define FLAG_CMPB 3
`define FLAG_CMPA 4
`define PRESC_BITS 10
`define TAP_8 2
`define TAP_64 5
`define TAP_256 7
`define TAP_1024 9
`define FILTER_LEN 4
`define MAX8 8'hFF
`define MAX16 16'hFFFF
`endif

/* File: rtl/timer_pkg.sv */
// timer block types
// assumes the defines header sits in the include path
package timer_pkg;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_sel_type;
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_type;
  typedef struct packed {
    logic cap_vec_ack;
    logic ovf_vec_ack;
    logic cmpa_vec_ack;
    logic cmpb_vec_ack;
  } vec_ack_type;
endpackage

/* File: rtl/capture_front.sv */
// capture front end: pin sync, source select, filter, edge detect
// assumes pins are asynchronous to clk_sys; comparator output likewise
`timescale 1ns/1ps
`include "timer_defines.svh"
module capture_front (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic comparator_capture_src,
  input wire logic capture_filter_en,
  input wire logic capture_edge_sel,
  output logic capture_event
);
  import timer_pkg::*;
  logic [2:0] pin_sync_r;
  logic [2:0] cmp_sync_r;
  logic [`FILTER_LEN-1:0] hist_r;
  logic filt_r;
  logic prev_r;
  logic src;
  logic level;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_sync_r <= 3'h0;
      cmp_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], capture_pin};
      cmp_sync_r <= {cmp_sync_r[1:0], comparator_out};
    end
  end

  always_comb begin
    if (comparator_capture_src)
      src = cmp_sync_r[2];
    else
      src = pin_sync_r[2];
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[`FILTER_LEN-2:0], src};
      if (&hist_r)
        filt_r <= 1'b1;
      else if (~|hist_r)
        filt_r <= 1'b0;
    end
  end

  assign level = capture_filter_en ? filt_r : src;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_r <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      prev_r <= level;
      capture_event <= capture_edge_sel ? (level & ~prev_r) : (~level & prev_r);
    end
  end
endmodule

/* File: rtl/timer_core.sv */
// 8/16-bit timer with capture, prescaler and shared high-byte latch
// assumes a cpu that drives sel/wr/rd for one cycle per byte access
// Operation
// - counter advances only on cycles where the tick enable is high
// - width bit set gives 16-bit counter and joined 16-bit compare
// - one shared 8-bit high-byte latch serves all 16-bit registers
// - low-byte write loads latch and written byte together
// - low-byte read copies high byte into latch same cycle
// - compare reads bypass latch; 16-bit capture value reads through latch
// - latch holds until next high-byte write or low-byte read of counter or capture value, reusable across registers
// - capture enable bit selects input capture mode
// - filter needs four equal samples, adding five cycles delay
// - edge select picks falling or rising; capture copies counter, sets flag
// - comparator source bit routes comparator into capture front end
// - reserved bits 2:1 of control A read zero
// - bit 0 of control A selects normal or clear-on-match counting in 8-bit mode
// - sync hold keeps prescaler reset; clearing sync clears it
// - prescaler reset bit resets prescaler, self-clears without sync
// - clock select: stop, div 1/8/64/256/1024, external falling/rising
// - external pin counted even when driven as an output
// - mode map from capture, width, clear bits; overflow at max
// - capture flag cleared by vector execution or writing one
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_core (
  input wire logic clk_sys,
  input wire logic reset,
  input timer_pkg::cpu_req_type cpu_req,
  input timer_pkg::vec_ack_type vec_ack,
  input wire logic capture_pin,
  input wire logic ext_count_pin,
  input wire logic comparator_out,
  output logic [7:0] cpu_rdata,
  output logic [4:0] flags_out,
  output logic [15:0] count_out
);
  import timer_pkg::*;
  logic [7:0] timer_ctrl_a_r;
  logic [7:0] timer_ctrl_b_r;
  logic [7:0] high_latch_r;
  logic [7:0] count_low_r;
  logic [7:0] count_high_r;
  logic [7:0] compare_a_r;
  logic [7:0] compare_b_r;
  logic [`PRESC_BITS-1:0] presc_r;
  logic [`PRESC_BITS-1:0] presc_nxt;
  logic [2:0] ext_sync_r;
  logic timer_tick;
  logic block_match_r;
  logic cap_flag_r;
  logic ovf_flag_r;
  logic cmpa_flag_r;
  logic cmpb_flag_r;
  logic capture_event;
  logic width_select;
  logic capture_mode_en;
  logic clear_on_match_mode;
  logic sync_hold_mode;
  logic prescaler_reset;
  clock_sel_type clock_sel;
  logic [15:0] count16;
  logic [15:0] compare16;
  logic [15:0] count_nxt;
  logic wr_cycle;
  logic rd_cycle;
  logic cap_wr;
  logic match_a;
  logic match_b;
  logic at_max;
  logic presc_tap;

  assign width_select = timer_ctrl_a_r[`A_WIDTH];
  assign capture_mode_en = timer_ctrl_a_r[`A_CAPEN];
  assign clear_on_match_mode = timer_ctrl_a_r[`A_CTC];
  assign sync_hold_mode = timer_ctrl_b_r[`B_SYNC];
  assign prescaler_reset = timer_ctrl_b_r[`B_PSR];
  assign clock_sel = clock_sel_type'(timer_ctrl_b_r[`B_CS_MSB:0]);
  assign count16 = {count_high_r, count_low_r};
  assign compare16 = {compare_b_r, compare_a_r};
  assign wr_cycle = cpu_req.sel & cpu_req.wr;
  assign rd_cycle = cpu_req.sel & cpu_req.rd;

  capture_front u_front (
    .clk_sys(clk_sys),
    .reset(reset),
    .capture_pin(capture_pin),
    .comparator_out(comparator_out),
    .comparator_capture_src(timer_ctrl_a_r[`A_ACIC]),
    .capture_filter_en(timer_ctrl_a_r[`A_FILT]),
    .capture_edge_sel(timer_ctrl_a_r[`A_EDGE]),
    .capture_event(capture_event)
  );

  assign cap_wr = capture_event & capture_mode_en;

  // prescaler cleared while reset bit set
  assign presc_nxt = prescaler_reset ? '0 : presc_r + `PRESC_BITS'(1);
  always_ff @(posedge clk_sys) begin
    if (reset)
      presc_r <= '0;
    else
      presc_r <= presc_nxt;
  end

  // pin sampled regardless of its port direction
  always_ff @(posedge clk_sys) begin
    if (reset)
      ext_sync_r <= 3'h0;
    else
      ext_sync_r <= {ext_sync_r[1:0], ext_count_pin};
  end

  always_comb begin
    presc_tap = 1'b0;
    case (clock_sel)
      CS_STOP: presc_tap = 1'b0;
      CS_DIV1: presc_tap = 1'b1;
      CS_DIV8: presc_tap = &presc_r[`TAP_8:0];
      CS_DIV64: presc_tap = &presc_r[`TAP_64:0];
      CS_DIV256: presc_tap = &presc_r[`TAP_256:0];
      CS_DIV1024: presc_tap = &presc_r[`TAP_1024:0];
      CS_EXT_FALL: presc_tap = ext_sync_r[2] & ~ext_sync_r[1];
      CS_EXT_RISE: presc_tap = ~ext_sync_r[2] & ext_sync_r[1];
      default: presc_tap = 1'b0;
    endcase
  end
  assign timer_tick = presc_tap & ~prescaler_reset;

  // mode map: top and overflow point
  always_comb begin
    match_a = 1'b0;
    match_b = 1'b0;
    if (width_select) begin
      at_max = (count16 == `MAX16);
      match_a = (count16 == compare16) & ~capture_mode_en;
    end else begin
      at_max = (count_low_r == `MAX8);
      match_a = (count_low_r == compare_a_r) & ~capture_mode_en;
      match_b = (count_low_r == compare_b_r) & ~capture_mode_en;
    end
  end

  always_comb begin
    count_nxt = count16 + 16'h0001;
    if (!width_select) begin
      count_nxt[15:8] = count_high_r;
      if (clear_on_match_mode && !capture_mode_en && match_a)
        count_nxt[7:0] = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset)
      block_match_r <= 1'b0;
    else if (wr_cycle && (cpu_req.addr == `ADDR_COUNT_LOW || cpu_req.addr == `ADDR_COUNT_HIGH))
      block_match_r <= 1'b1;
    else if (timer_tick)
      block_match_r <= 1'b0;
  end

  // counter with cpu write taking priority over ticking
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_low_r <= 8'h00;
      count_high_r <= 8'h00;
    end else if (wr_cycle && cpu_req.addr == `ADDR_COUNT_LOW) begin
      count_low_r <= cpu_req.wdata;
      if (width_select)
        count_high_r <= high_latch_r;
    end else if (wr_cycle && cpu_req.addr == `ADDR_COUNT_HIGH && !width_select) begin
      count_high_r <= cpu_req.wdata;
    end else if (timer_tick) begin
      count_low_r <= count_nxt[7:0];
      count_high_r <= count_nxt[15:8];
    end
  end

  // compare bytes double as capture register in capture mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_a_r <= 8'h00;
      compare_b_r <= 8'h00;
    end else if (cap_wr) begin
      compare_a_r <= count_low_r;
      if (width_select)
        compare_b_r <= count_high_r;
    end else if (wr_cycle && cpu_req.addr == `ADDR_COMPARE_A) begin
      compare_a_r <= cpu_req.wdata;
      if (width_select)
        compare_b_r <= high_latch_r;
    end else if (wr_cycle && cpu_req.addr == `ADDR_COMPARE_B && !width_select) begin
      compare_b_r <= cpu_req.wdata;
    end
  end

  // single shared latch; held until high write; low read fills it
  always_ff @(posedge clk_sys) begin
    if (reset)
      high_latch_r <= 8'h00;
    else if (width_select && wr_cycle &&
             (cpu_req.addr == `ADDR_COUNT_HIGH || cpu_req.addr == `ADDR_COMPARE_B))
      high_latch_r <= cpu_req.wdata;
    else if (width_select && rd_cycle && cpu_req.addr == `ADDR_COUNT_LOW)
      high_latch_r <= count_high_r;
    // capture value goes through the latch
    else if (width_select && rd_cycle && cpu_req.addr == `ADDR_COMPARE_A && capture_mode_en)
      high_latch_r <= compare_b_r;
  end

  always_ff @(posedge clk_sys) begin
    if (reset)
      timer_ctrl_a_r <= `CTRL_A_RESET;
    else if (wr_cycle && cpu_req.addr == `ADDR_CTRL_A)
      timer_ctrl_a_r <= cpu_req.wdata & `CTRL_A_WMASK;
  end

  // sync hold keeps reset bit; self-clear otherwise
  always_ff @(posedge clk_sys) begin
    if (reset)
      timer_ctrl_b_r <= `CTRL_B_RESET;
    else if (wr_cycle && cpu_req.addr == `ADDR_CTRL_B)
      timer_ctrl_b_r <= cpu_req.wdata & `CTRL_B_WMASK;
    else if (!sync_hold_mode)
      timer_ctrl_b_r[`B_PSR] <= 1'b0;
  end

  // flags: set wins over vector or write-one clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cap_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      cmpa_flag_r <= 1'b0;
      cmpb_flag_r <= 1'b0;
    end else begin
      if (cap_wr)
        cap_flag_r <= 1'b1;
      else if (vec_ack.cap_vec_ack || (wr_cycle && cpu_req.addr == `ADDR_FLAGS && cpu_req.wdata[`FLAG_CAP]))
        cap_flag_r <= 1'b0;
      if (timer_tick && at_max)
        ovf_flag_r <= 1'b1;
      else if (vec_ack.ovf_vec_ack || (wr_cycle && cpu_req.addr == `ADDR_FLAGS && cpu_req.wdata[`FLAG_OVF]))
        ovf_flag_r <= 1'b0;
      if (timer_tick && match_a && !block_match_r)
        cmpa_flag_r <= 1'b1;
      else if (vec_ack.cmpa_vec_ack || (wr_cycle && cpu_req.addr == `ADDR_FLAGS && cpu_req.wdata[`FLAG_CMPA]))
        cmpa_flag_r <= 1'b0;
      if (timer_tick && match_b && !block_match_r)
        cmpb_flag_r <= 1'b1;
      else if (vec_ack.cmpb_vec_ack || (wr_cycle && cpu_req.addr == `ADDR_FLAGS && cpu_req.wdata[`FLAG_CMPB]))
        cmpb_flag_r <= 1'b0;
    end
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_rdata <= 8'h00;
    end else if (rd_cycle) begin
      case (cpu_req.addr)
        // reserved bits masked at write, so read zero
        `ADDR_CTRL_A: cpu_rdata <= timer_ctrl_a_r;
        `ADDR_CTRL_B: cpu_rdata <= timer_ctrl_b_r;
        `ADDR_COUNT_LOW: cpu_rdata <= count_low_r;
        `ADDR_COUNT_HIGH: cpu_rdata <= width_select ? high_latch_r : count_high_r;
        `ADDR_COMPARE_A: cpu_rdata <= compare_a_r;
        // compare read direct, capture through latch
        `ADDR_COMPARE_B: cpu_rdata <= (width_select && capture_mode_en) ? high_latch_r : compare_b_r;
        `ADDR_FLAGS: cpu_rdata <= {3'h0, cmpa_flag_r, cmpb_flag_r, 1'b0, ovf_flag_r, cap_flag_r};
        default: cpu_rdata <= 8'h00;
      endcase
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_out <= 5'h00;
      count_out <= 16'h0000;
    end else begin
      flags_out <= {cmpa_flag_r, cmpb_flag_r, 1'b0, ovf_flag_r, cap_flag_r};
      count_out <= count16;
    end
  end
endmodule

/* File: tb/timer_core_asserts.sv */
// checker on timer_core ports: control reads, 16-bit access, counting
// assumes bind from tb_top, one clock, sync reset
`timescale 1ns/1ps
module timer_core_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input timer_pkg::cpu_req_type cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire logic [15:0] count_out
);
  import timer_pkg::*;
  logic [7:0] a_r;
  logic [7:0] b_r;
  logic [2:0] quiet_r;
  wire logic rd_q = cpu_req.sel & cpu_req.rd;
  wire logic wr_q = cpu_req.sel & cpu_req.wr;
  wire logic [7:0] cnt_hi = count_out[15:8];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // control shadow; prescaler reset survives only under sync hold
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      a_r <= 8'h00;
      b_r <= 8'h00;
    end else if (wr_q && cpu_req.addr == 8'h15) begin
      a_r <= cpu_req.wdata & 8'hF9;
    end else if (wr_q && cpu_req.addr == 8'h33) begin
      b_r <= {3'h0, cpu_req.wdata[4], cpu_req.wdata[4] & cpu_req.wdata[3], cpu_req.wdata[2:0]};
    end
  end
  // saturating age of last write, lets the tick pipeline settle
  always_ff @(posedge clk_sys) begin
    quiet_r <= (reset || wr_q) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
  end
  sequence s_rd(a);
    rd_q && cpu_req.addr == a;
  endsequence
  sequence s_wr16;
    a_r[7] && b_r[2:0] == 3'h0 && wr_q && cpu_req.addr == 8'h14 ##1 wr_q && cpu_req.addr == 8'h12;
  endsequence
  property p_rdata_idle;
    !rd_q |=> cpu_rdata == 8'h00;
  endproperty
  property p_ctrl_a;
    s_rd(8'h15) |=> cpu_rdata == a_r;
  endproperty
  property p_ctrl_b;
    s_rd(8'h33) |=> cpu_rdata == b_r;
  endproperty
  property p_stop;
    quiet_r == 3'h7 && b_r[2:0] == 3'h0 |=> $stable(count_out);
  endproperty
  property p_div1;
    quiet_r == 3'h7 && b_r == 8'h01 && a_r[7] |=> count_out == $past(count_out) + 16'h0001;
  endproperty
  property p_low_rd;
    s_rd(8'h12) |=> cpu_rdata == count_out[7:0];
  endproperty
  property p_latch;
    a_r[7] ##0 s_rd(8'h12) ##1 s_rd(8'h14) |=> cpu_rdata == $past(cnt_hi);
  endproperty
  property p_wr16;
    s_wr16 |=> ##1 count_out == {$past(cpu_req.wdata, 3), $past(cpu_req.wdata, 2)};
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_ctrl_a: assert property (p_ctrl_a) else $error("control a readback wrong");
  a_ctrl_b: assert property (p_ctrl_b) else $error("control b readback wrong");
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  a_div1: assert property (p_div1) else $error("undivided count did not step by one");
  a_low_rd: assert property (p_low_rd) else $error("low byte read wrong");
  a_latch: assert property (p_latch) else $error("high byte not from latch");
  a_wr16: assert property (p_wr16) else $error("16-bit write not joined");
endmodule

/* File: tb/cpu_host.sv */
// host cpu model: single-cycle byte accesses on the timer port
// assumes callers resume one step after a rising edge
`timescale 1ns/1ps
module cpu_host (
  input wire logic clk_sys,
  input wire logic [7:0] cpu_rdata,
  output timer_pkg::cpu_req_type cpu_req
);
  import timer_pkg::*;
  initial cpu_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cpu_req = '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    q = cpu_rdata;
  endtask
  task automatic idle;
    cpu_req.sel = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // high first, back to back, nothing between
  task automatic wr16(input logic [7:0] hi_a, input logic [7:0] lo_a, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, hi_a, v[15:8], q);
    acc(1'b1, lo_a, v[7:0], q);
    idle();
  endtask
  // low first so the latch holds the matching high
  task automatic rd16(input logic [7:0] lo_a, input logic [7:0] hi_a, output logic [15:0] v);
    acc(1'b0, lo_a, 8'h00, v[7:0]);
    acc(1'b0, hi_a, 8'h00, v[15:8]);
    idle();
  endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for timer_core, host model drives the port
// assumes rtl package and defines compiled first
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  cpu_req_type cpu_req;
  vec_ack_type vec_ack = '0;
  logic capture_pin = 1'b0;
  logic ext_count_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic [7:0] cpu_rdata;
  logic [7:0] q;
  logic [4:0] flags_out;
  logic [15:0] count_out;
  logic [15:0] v1;
  logic [15:0] v2;
  int n;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  timer_core uut (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req), .vec_ack(vec_ack),
    .capture_pin(capture_pin), .ext_count_pin(ext_count_pin), .comparator_out(comparator_out),
    .cpu_rdata(cpu_rdata), .flags_out(flags_out), .count_out(count_out));
  cpu_host host (.clk_sys(clk_sys), .cpu_rdata(cpu_rdata), .cpu_req(cpu_req));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] exp_b(input logic [7:0] w);
    return {3'h0, w[4], w[4] & w[3], w[2:0]};
  endfunction
  // 8-bit clear-on-match count after k ticks, wraps past max to zero
  function automatic logic [7:0] exp_ctc(input logic [7:0] c, input logic [7:0] top, input int k);
    logic [7:0] n8;
    n8 = c;
    for (int j = 0; j < k; j++) begin
      n8 = (n8 == top) ? 8'h00 : n8 + 8'h01;
    end
    return n8;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // generous ceiling, the sequence needs under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  initial begin
    n = $urandom(32'h512EAECD);
    wait_cyc(20);
    reset = 1'b0;
    // pass 0 checks reset values, the rest random writes
    for (int i = 0; i < 10; i++) begin
      v1 = (i == 0) ? 16'h0000 : 16'($urandom);
      if (i > 0) begin
        host.acc(1'b1, 8'h15, v1[7:0], q);
        host.acc(1'b1, 8'h33, v1[15:8], q);
        host.acc(1'b1, 8'h00, v1[7:0], q);
      end
      host.acc(1'b0, 8'h15, 8'h00, q);
      chk(q, v1[7:0] & 8'hF9);
      host.acc(1'b0, 8'h33, 8'h00, q);
      chk(q, exp_b(v1[15:8]));
      host.acc(1'b0, 8'h00, 8'h00, q);
      chk(q, 8'h00);
      host.idle();
    end
    host.acc(1'b1, 8'h15, 8'h80, q);
    host.acc(1'b1, 8'h33, 8'h00, q);
    v1 = 16'($urandom);
    v2 = 16'($urandom);
    host.acc(1'b1, 8'h14, v1[15:8], q);
    host.acc(1'b1, 8'h13, v2[7:0], q);
    host.acc(1'b1, 8'h12, v1[7:0], q);
    host.acc(1'b1, 8'h14, v2[15:8], q);
    host.acc(1'b0, 8'h11, 8'h00, q);
    chk(q, v1[15:8]);
    host.acc(1'b0, 8'h13, 8'h00, q);
    chk(q, v2[7:0]);
    host.rd16(8'h12, 8'h14, v2);
    chk(v2, v1);
    host.acc(1'b1, 8'h33, 8'h01, q);
    host.rd16(8'h12, 8'h14, v1);
    wait_cyc(10);
    host.rd16(8'h12, 8'h14, v2);
    chk(v2 - v1, 16'h000D);
    // sync hold with prescaler reset kept: counter frozen
    host.acc(1'b1, 8'h33, 8'h1A, q);
    host.rd16(8'h12, 8'h14, v1);
    wait_cyc(40);
    host.rd16(8'h12, 8'h14, v2);
    chk(v2, v1);
    for (int m = 6; m < 8; m++) begin
      host.acc(1'b1, 8'h33, 8'(m), q);
      host.rd16(8'h12, 8'h14, v1);
      n = 1 + $urandom % 8;
      repeat (n) begin
        ext_count_pin = 1'b1;
        wait_cyc(6);
        ext_count_pin = 1'b0;
        wait_cyc(6);
      end
      host.rd16(8'h12, 8'h14, v2);
      chk(v2 - v1, 16'(n));
    end
    // filter, edge and source in every combination
    for (int i = 0; i < 8; i++) begin
      capture_pin = !i[1];
      comparator_out = !i[1];
      wait_cyc(16);
      host.acc(1'b1, 8'h15, {2'h3, i[0], i[1], i[2], 3'h0}, q);
      host.acc(1'b1, 8'h33, 8'h00, q);
      v1 = 16'($urandom);
      host.wr16(8'h14, 8'h12, v1);
      host.acc(1'b1, 8'h18, 8'h1B, q);
      host.idle();
      if (i[2]) capture_pin = i[1];
      else comparator_out = i[1];
      wait_cyc(16);
      host.acc(1'b0, 8'h18, 8'h00, q);
      chk(q, 8'h00);
      if (i[2]) comparator_out = i[1];
      else capture_pin = i[1];
      wait_cyc(16);
      host.rd16(8'h13, 8'h11, v2);
      chk(v2, v1);
      host.acc(1'b0, 8'h18, 8'h00, q);
      chk(q, 8'h01);
      chk(16'(flags_out), 16'h0001);
      host.idle();
      if (i[0]) begin
        host.acc(1'b1, 8'h18, 8'h01, q);
      end else begin
        vec_ack.cap_vec_ack = 1'b1;
        wait_cyc(1);
        vec_ack.cap_vec_ack = 1'b0;
      end
      host.acc(1'b0, 8'h18, 8'h00, q);
      chk(q, 8'h00);
      chk(16'(flags_out), 16'h0000);
      host.idle();
    end
    // start near max in 8-bit clear-on-match: one overflow, then wraps at top
    host.acc(1'b1, 8'h15, 8'h01, q);
    host.acc(1'b1, 8'h33, 8'h00, q);
    v1 = 16'h00F0 + 16'($urandom % 16);
    v2 = 16'(1 + $urandom % 8);
    host.acc(1'b1, 8'h13, v2[7:0], q);
    host.acc(1'b1, 8'h11, 8'h40, q);
    host.acc(1'b1, 8'h12, v1[7:0], q);
    host.acc(1'b1, 8'h18, 8'h1B, q);
    host.acc(1'b1, 8'h33, 8'h01, q);
    wait_cyc(40);
    // the stopping write still sees one last tick, 41 in all
    host.acc(1'b1, 8'h33, 8'h00, q);
    host.acc(1'b0, 8'h12, 8'h00, q);
    chk(q, exp_ctc(v1[7:0], v2[7:0], 41));
    host.acc(1'b0, 8'h18, 8'h00, q);
    chk(q, 8'h12);
    chk(16'(flags_out), 16'h0012);
    results();
  end
endmodule
bind timer_core timer_core_asserts chk_u (.clk_sys(clk_sys), .reset(reset), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .count_out(count_out));
